// *** verif/pss_top_bench.sv ***
// self-checking bench for the program sequencer
`timescale 1ns/1ps
`default_nettype none
module pss_top_bench;
	import pss_pkg::*;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  romData = 8'h00;
	logic [3:0]  accIn = 4'h0, ramIn = 4'h0, digitIn = 4'h0;
	logic [11:0] retAddr = 12'h000;
	logic        testIn = 1'b0;
	logic [11:0] romAddr, pcOut, stackAddr;
	logic        nopSlot, latchLoad, memWrite, accWrite, digitWrite;
	logic        stackPush, stackPop, carryFlag, skipFlag;
	logic [7:0]  latchData, memData;
	logic [3:0]  accData, digitData;
	pss_state_t  seqState;
	logic [7:0]  rom [0:4095];
	int          errTotal = 0;
	int          testsRun = 0;

	initial forever #2 clk = ~clk;
	// rom answers the fetch address; refreshed off the sampling edge
	always @(negedge clk) romData <= rom[romAddr];

	pss_top #(.PCW(12)) dut_u (.clk(clk), .arst_n(arst_n), .romData(romData), .accIn(accIn),
		.ramIn(ramIn), .digitIn(digitIn), .retAddr(retAddr), .testIn(testIn),
		.romAddr(romAddr), .pcOut(pcOut), .nopSlot(nopSlot), .latchLoad(latchLoad),
		.latchData(latchData), .memWrite(memWrite), .memData(memData), .accWrite(accWrite),
		.accData(accData), .digitWrite(digitWrite), .digitData(digitData),
		.stackPush(stackPush), .stackAddr(stackAddr), .stackPop(stackPop),
		.carryFlag(carryFlag), .skipFlag(skipFlag), .seqState(seqState));

	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		testsRun++;
		if (seen !== exp) begin
			errTotal++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// hold reset and wipe the program; zero bytes decode as nops
	task automatic clear();
		@(negedge clk);
		arst_n = 1'b0;
		foreach (rom[i]) rom[i] = 8'h00;
	endtask
	// release off the sampling edge so byte 0 executes at the next edge
	task automatic go();
		repeat (8) @(negedge clk);
		arst_n = 1'b1;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// page-end jump, page-2 call, extended jumps inside pages 2 and 3
	task automatic tJumps();
		clear();
		{rom[0], rom[1], rom['h13F], rom['h145], rom['h85], rom['h83]} = 48'h613F_C585_83E0;
		go();
		chk("reset state", seqState, ST_EXEC);
		step(2);
		chk("pc", pcOut, 'h13F);
		step(1);
		chk("pc", pcOut, 'h145);
		step(1);
		chk("pc", pcOut, 'h085);
		chk("push addr", stackAddr, 'h146);
		step(1);
		chk("pc", pcOut, 'h083);
		chk("push", stackPush, 0);
		step(1);
		chk("pc", pcOut, 'h0E0);
		$display("jumps done");
	endtask
	// latch look-up at a block end reads the next block
	task automatic tLook();
		clear();
		{rom[0], rom[1], rom['hFF], rom['h135], rom['h35]} = 40'h60FF_BF5A_A5;
		{accIn, ramIn} = 8'h35;
		go();
		step(3);
		chk("look addr", romAddr, 'h135);
		chk("state", seqState, ST_LOOK);
		step(1);
		chk("latch", latchLoad, 1);
		chk("latch data", latchData, 'h5A);
		chk("push", stackPush, 0);
		chk("pc", pcOut, 'h100);
		$display("lookup done");
	endtask
	// indirect jump at block end with both nibbles 15: two blocks on
	task automatic tIndirect();
		clear();
		{rom[0], rom[1], rom['h1FF], rom['h2FF]} = 32'h61FF_FF12;
		{accIn, ramIn} = 8'hFF;
		go();
		step(4);
		chk("pc", pcOut, 'h312);
		$display("indirect done");
	endtask
	// adds, carry flag and skip slots
	task automatic tCarry();
		clear();
		{rom[0], rom[1], rom[2], rom[3], rom[4], rom[5], rom[6], rom[7]} = 64'h2230_6040_315F_2020;
		{accIn, ramIn} = 8'h88;
		go();
		step(2);
		chk("sum", accData, 1);
		chk("carry skip", {carryFlag, skipFlag}, 3);
		step(1);
		chk("nop", nopSlot, 1);
		step(1);
		chk("nop pc", {nopSlot, pcOut}, 'h1004);
		step(1);
		chk("plain add", {accData, carryFlag, skipFlag}, 2);
		chk("acc write", accWrite, 1'b1);
		step(1);
		chk("imm add", {accData, carryFlag, skipFlag}, 'h1F);
		step(2);
		chk("carry test", skipFlag, 1);
		$display("carry done");
	endtask
	// pointer-load chain, digit wrap, return-and-skip
	task automatic tPointer();
		clear();
		{rom[0], rom[1], rom[2]} = 24'h0B0C_0D;
		{rom['h10], rom['h11], rom['h12], rom['h201]} = 32'h0400_4907;
		{digitIn, retAddr} = 16'hF200;
		go();
		step(1);
		chk("digit", {digitWrite, digitData}, 'h13);
		step(2);
		chk("chain", {nopSlot, digitData}, 'h13);
		clear();
		{rom[0], rom[1], rom[2], rom['h201], rom['h202]} = 40'h04_0049_0707;
		go();
		step(1);
		chk("wrap", {digitData, skipFlag}, 1);
		step(2);
		chk("pop", {stackPop, skipFlag, pcOut}, 'h3200);
		step(1);
		chk("ret nop", {nopSlot, pcOut}, 'h1201);
		step(1);
		chk("dec", {digitData, skipFlag}, 'h1C);
		// digit at zero so the second decrement wraps to 15
		@(negedge clk);
		digitIn = 4'h0;
		step(1);
		chk("dec wrap", {digitData, skipFlag}, 5'h1F);
		$display("pointer done");
	endtask
	// chapter-end long jump, memory look-up, long call
	task automatic tChapter();
		clear();
		{rom[0], rom[1], rom['h7FE], rom['h7FF], rom['h810], rom['h821]} = 48'h67FE_6010_23C3;
		{rom['h812], rom['h813], accIn, ramIn} = 24'h6A34_21;
		go();
		step(4);
		chk("pc", pcOut, 'h810);
		step(3);
		chk("mem", {memWrite, memData}, 'h1C3);
		chk("pc", pcOut, 'h812);
		step(2);
		chk("call", {stackPush, pcOut}, 'h1A34);
		chk("push addr", stackAddr, 'h814);
		$display("chapter done");
	endtask

	// carry clear, complement add, test input, decimal-adjust add, plain return
	task automatic tMisc();
		clear();
		{rom[0], rom[1], rom[2], rom[3], rom[4], rom[5], rom[6], rom[7]} = 64'h2232_1021_2100_4A48;
		{accIn, ramIn, testIn} = 9'h07D;
		retAddr = 12'h155;
		go();
		step(3);
		chk("compl add", {accWrite, accData, carryFlag, skipFlag}, 7'h6B);
		step(1);
		chk("test nop", nopSlot, 1'b1);
		step(1);
		chk("test skip", skipFlag, 1'b1);
		step(2);
		chk("adjust add", {accWrite, accData, carryFlag, skipFlag}, 7'h76);
		step(1);
		chk("return", {stackPop, skipFlag, pcOut}, 14'h2155);
		$display("misc done");
	endtask

	initial begin
		foreach (rom[i]) rom[i] = 8'h00;
		tJumps();
		tLook();
		tIndirect();
		tCarry();
		tPointer();
		tChapter();
		tMisc();
		conclude();
	end
endmodule // pss_top_bench
`default_nettype wire

// *** verilog/pss_alu.sv ***
// four-bit adder for the skipping and plain additions
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.svh"
module pss_alu (
	pss_if.alu bus  // adder side of the bundle
);
	import pss_pkg::*;
	logic [4:0] sum5;
	// five-bit sum keeps the carry out apart from the stored flag
	always_comb begin
		sum5 = {1'b0, bus.acc};
		case (bus.aluMode)
			ALU_ASC:  sum5 = {1'b0, bus.acc} + {1'b0, bus.ram} + {4'h0, bus.carryIn};
			ALU_COMPLEMENT_ADD_CARRY_SKIP: sum5 = {1'b0, ~bus.acc} + {1'b0, bus.ram} + {4'h0, bus.carryIn};
			ALU_ADD_IMMEDIATE_SKIP: sum5 = {1'b0, bus.acc} + {1'b0, bus.op[3:0]};
			ALU_ADD:  sum5 = {1'b0, bus.acc} + {1'b0, bus.ram};
			ALU_ADT:  sum5 = {1'b0, bus.acc} + {1'b0, `PSS_ADT_K};
			default:  sum5 = {1'b0, bus.acc};
		endcase
	end
	assign bus.aluSum   = sum5[3:0];
	assign bus.aluCarry = sum5[4];
endmodule // pss_alu
`default_nettype wire

// *** verilog/pss_consts.svh ***
// opcode, address-field and constant values for the program sequencer
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
// two top opcode bits selecting the single-byte transfers
`define PSS_TOP_CALL    2'h2
`define PSS_TOP_JUMP    2'h3
// single-byte look-ups carved out of the transfer ranges
`define PSS_OP_TLATCH   8'hBF
`define PSS_OP_IJUMP    8'hFF
// two-byte codes: long transfers by upper five opcode bits, memory look-up by full byte
`define PSS_OP_LJUMP    5'h0C
`define PSS_OP_LCALL    5'h0D
`define PSS_OP_TMEM     8'h23
// arithmetic
`define PSS_OP_ASC      8'h30
`define PSS_OP_COMPLEMENT_ADD_CARRY_SKIP     8'h10
`define PSS_OP_ADD_IMMEDIATE_SKIP     4'h5
`define PSS_OP_ADD      8'h31
`define PSS_OP_ADT      8'h4A
`define PSS_ADT_K       4'hA
// pointer, tests, returns, carry control
`define PSS_OP_LBI      5'h01
`define PSS_OP_XIS      8'h04
`define PSS_OP_XDS      8'h07
`define PSS_OP_RETURN_AND_SKIP    8'h49
`define PSS_OP_RET      8'h48
`define PSS_OP_SKC      8'h20
`define PSS_OP_SKT      8'h21
`define PSS_OP_SC       8'h22
`define PSS_OP_RC       8'h32
// address fields: page, subroutine pages, block, chapter
`define PSS_PAGE_LSB    6
`define PSS_SUB_LSB     7
`define PSS_BLK_LSB     8
`define PSS_CHAP_LSB    11
`define PSS_SUB_PAGES   1
`define PSS_NIB_MAX     4'hF
`define PSS_NIB_MIN     4'h0
`endif

// *** verilog/pss_if.sv ***
// signal bundle between the sequencer and its address and adder helpers
`timescale 1ns/1ps
`default_nettype none
interface pss_if #(parameter int PCW = 12);
	import pss_pkg::*;
	logic [PCW-1:0] pc;       // address of the executing byte
	logic [7:0]     op;       // fetched byte
	logic [3:0]     acc;      // accumulator
	logic [3:0]     ram;      // ram nibble at pointer
	logic           carryIn;  // stored carry flag
	pss_alu_t       aluMode;  // adder function
	logic [PCW-1:0] pcInc;    // pre-incremented pc
	logic           inSub;    // pcInc lies in pages 2 and 3
	logic [PCW-1:0] sJump;    // short jump target
	logic [PCW-1:0] sCall;    // page-2 call target
	logic [PCW-1:0] lookAddr; // table word inside the block
	logic [PCW-9:0] lookHi;   // block of the word after the table word
	logic [3:0]     aluSum;   // four-bit sum
	logic           aluCarry; // carry out of the adder
	modport seq  (output pc, op, acc, ram, carryIn, aluMode,
		input pcInc, inSub, sJump, sCall, lookAddr, lookHi, aluSum, aluCarry);
	modport addr (input pc, op, acc, ram,
		output pcInc, inSub, sJump, sCall, lookAddr, lookHi);
	modport alu  (input acc, ram, op, carryIn, aluMode, output aluSum, aluCarry);
endinterface // pss_if
`default_nettype wire

// *** verilog/pss_next_addr.sv ***
// next-address arithmetic: increment, short targets, table addresses
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.svh"
module pss_next_addr #(parameter int PCW = 12) (
	pss_if.addr bus  // address side of the bundle
);
	import pss_pkg::*;
	logic [PCW-1:0] lookNext;
	// pc is always bumped first, so the short jump and table targets are built from pcInc
	assign bus.pcInc = bus.pc + PCW'(1);
	assign bus.inSub = (bus.pcInc[PCW-1:`PSS_SUB_LSB] == (PCW-`PSS_SUB_LSB)'(`PSS_SUB_PAGES));
	// short targets: six bits normally, seven inside pages 2 and 3
	always_comb begin
		bus.sJump = {bus.pcInc[PCW-1:`PSS_PAGE_LSB], bus.op[`PSS_PAGE_LSB-1:0]};
		if (bus.inSub) begin
			bus.sJump = {bus.pcInc[PCW-1:`PSS_SUB_LSB], bus.op[`PSS_SUB_LSB-1:0]};
		end
	end
	assign bus.sCall = {{(PCW-`PSS_BLK_LSB){1'b0}}, `PSS_TOP_CALL, bus.op[`PSS_PAGE_LSB-1:0]};
	assign bus.lookAddr = {bus.pcInc[PCW-1:`PSS_BLK_LSB], bus.acc, bus.ram};
	// table word is stepped past too
	assign lookNext = bus.lookAddr + PCW'(1);
	assign bus.lookHi = lookNext[PCW-1:`PSS_BLK_LSB];
endmodule // pss_next_addr
`default_nettype wire

// *** verilog/pss_pkg.sv ***
// types shared by the program sequencer modules
`default_nettype none
package pss_pkg;
	// sequencer slot states, one-hot
	typedef enum logic [2:0] {
		ST_EXEC   = 3'h1,
		ST_SECOND = 3'h2,
		ST_LOOK   = 3'h4
	} pss_state_t;
	// decoded instruction classes
	typedef enum logic [4:0] {
		OC_NONE, OC_SJUMP, OC_SCALL, OC_TLATCH, OC_TMEM, OC_IJUMP, OC_LJUMP,
		OC_LCALL, OC_ASC, OC_COMPLEMENT_ADD_CARRY_SKIP, OC_ADD_IMMEDIATE_SKIP, OC_ADD, OC_ADT, OC_LBI, OC_XIS,
		OC_XDS, OC_RETURN_AND_SKIP, OC_RET, OC_SKC, OC_SKT, OC_SC, OC_RC
	} pss_class_t;
	// adder functions
	typedef enum logic [2:0] {
		ALU_PASS, ALU_ASC, ALU_COMPLEMENT_ADD_CARRY_SKIP, ALU_ADD_IMMEDIATE_SKIP, ALU_ADD, ALU_ADT
	} pss_alu_t;
endpackage
`default_nettype wire

// *** verilog/pss_top.sv ***
// program sequencer: next address, look-ups, skip and carry handling
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.svh"
module pss_top #(parameter int PCW = 12) (
	input  wire logic           clk,      // core clock
	input  wire logic           arst_n,   // asynchronous reset, active low
	input  wire logic [7:0]     romData,  // program byte at romAddr
	input  wire logic [3:0]     accIn,    // accumulator value
	input  wire logic [3:0]     ramIn,    // ram nibble at pointer
	input  wire logic [3:0]     digitIn,  // pointer digit field
	input  wire logic [PCW-1:0] retAddr,  // top of return stack
	input  wire logic           testIn,   // core test condition
	output logic [PCW-1:0]      romAddr,  // program fetch address
	output logic [PCW-1:0]      pcOut,    // program counter
	output logic                nopSlot,  // forced nop cycle
	output logic                latchLoad, // output latch write
	output logic [7:0]          latchData, // output latch value
	output logic                memWrite, // acc and ram write
	output logic [7:0]          memData,  // ram high, acc low
	output logic                accWrite, // adder result write
	output logic [3:0]          accData,  // adder result
	output logic                digitWrite, // pointer digit write
	output logic [3:0]          digitData, // pointer digit value
	output logic                stackPush, // call push
	output logic [PCW-1:0]      stackAddr, // return address pushed
	output logic                stackPop, // return pop
	output logic                carryFlag, // stored carry
	output logic                skipFlag, // skip pending
	output pss_pkg::pss_state_t seqState  // slot state
);
	import pss_pkg::*;

	localparam int FARW = `PSS_CHAP_LSB - `PSS_BLK_LSB;

	// ------------------------------------------------------------
	// state record
	// ------------------------------------------------------------
	typedef struct packed {
		pss_state_t         st;
		logic [PCW-1:0]     pc;
		logic [PCW-1:0]     fetch;
		logic               skip;
		logic               carry;
		logic               nop;
		logic               isCall;
		logic               isMem;
		logic               isJump;
		logic [FARW-1:0]    farHi;
		logic [PCW-9:0]     jumpHi;
		logic [7:0]         latchData;
		logic               latchLoad;
		logic [7:0]         memData;
		logic               memWrite;
		logic [3:0]         accData;
		logic               accWrite;
		logic [3:0]         digitData;
		logic               digitWrite;
		logic [PCW-1:0]     pushAddr;
		logic               push;
		logic               pop;
		logic               nopSlot;
	} pss_regs_t;

	localparam pss_regs_t REG_RST = '{st: ST_EXEC, default: '0};

	pss_regs_t  state_r;
	pss_regs_t  state_nxt;
	pss_class_t cls;
	logic       go;

	pss_if #(.PCW(PCW)) bus ();

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// carved-out codes are checked before the transfer ranges
	function automatic pss_class_t pssDecode(input logic [7:0] op);
		pss_class_t c;
		c = OC_NONE;
		if (op == `PSS_OP_TLATCH) begin
			c = OC_TLATCH;
		end else if (op == `PSS_OP_IJUMP) begin
			c = OC_IJUMP;
		end else if (op[7:6] == `PSS_TOP_CALL) begin
			c = OC_SCALL;
		end else if (op[7:6] == `PSS_TOP_JUMP) begin
			c = OC_SJUMP;
		end else if (op[7:3] == `PSS_OP_LJUMP) begin
			c = OC_LJUMP;
		end else if (op[7:3] == `PSS_OP_LCALL) begin
			c = OC_LCALL;
		end else if (op[7:4] == `PSS_OP_ADD_IMMEDIATE_SKIP) begin
			c = OC_ADD_IMMEDIATE_SKIP;
		end else if (op[7:3] == `PSS_OP_LBI) begin
			c = OC_LBI;
		end else begin
			case (op)
				`PSS_OP_TMEM:  c = OC_TMEM;
				`PSS_OP_ASC:   c = OC_ASC;
				`PSS_OP_COMPLEMENT_ADD_CARRY_SKIP:  c = OC_COMPLEMENT_ADD_CARRY_SKIP;
				`PSS_OP_ADD:   c = OC_ADD;
				`PSS_OP_ADT:   c = OC_ADT;
				`PSS_OP_XIS:   c = OC_XIS;
				`PSS_OP_XDS:   c = OC_XDS;
				`PSS_OP_RETURN_AND_SKIP: c = OC_RETURN_AND_SKIP;
				`PSS_OP_RET:   c = OC_RET;
				`PSS_OP_SKC:   c = OC_SKC;
				`PSS_OP_SKT:   c = OC_SKT;
				`PSS_OP_SC:    c = OC_SC;
				`PSS_OP_RC:    c = OC_RC;
				default:       c = OC_NONE;
			endcase
		end
		return c;
	endfunction

	// byte count decides how many nop cycles a skip costs
	function automatic logic twoByte(input pss_class_t c);
		return (c == OC_TMEM) || (c == OC_LJUMP) || (c == OC_LCALL);
	endfunction

	assign cls = pssDecode(romData);
	assign go  = (state_r.st == ST_EXEC) && !state_r.skip;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	assign bus.pc      = state_r.pc;
	assign bus.op      = romData;
	assign bus.acc     = accIn;
	assign bus.ram     = ramIn;
	assign bus.carryIn = state_r.carry;
	// adder function follows the opcode class
	always_comb begin
		case (cls)
			OC_ASC:  bus.aluMode = ALU_ASC;
			OC_COMPLEMENT_ADD_CARRY_SKIP: bus.aluMode = ALU_COMPLEMENT_ADD_CARRY_SKIP;
			OC_ADD_IMMEDIATE_SKIP: bus.aluMode = ALU_ADD_IMMEDIATE_SKIP;
			OC_ADD:  bus.aluMode = ALU_ADD;
			OC_ADT:  bus.aluMode = ALU_ADT;
			default: bus.aluMode = ALU_PASS;
		endcase
	end

	pss_next_addr #(.PCW(PCW)) u_addr (
		.bus (bus.addr)
	);

	pss_alu u_alu (
		.bus (bus.alu)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		state_nxt            = state_r;
		state_nxt.latchLoad  = 1'b0;
		state_nxt.memWrite   = 1'b0;
		state_nxt.accWrite   = 1'b0;
		state_nxt.digitWrite = 1'b0;
		state_nxt.push       = 1'b0;
		state_nxt.pop        = 1'b0;
		state_nxt.nopSlot    = 1'b0;
		case (state_r.st)
			ST_EXEC: begin
				state_nxt.pc    = bus.pcInc;
				state_nxt.fetch = bus.pcInc;
				if (state_r.skip) begin
					state_nxt.nopSlot = 1'b1;
					state_nxt.skip = (cls == OC_LBI);
					if (twoByte(cls)) begin
						state_nxt.st  = ST_SECOND;
						state_nxt.nop = 1'b1;
					end
				end else begin
					state_nxt.skip = 1'b0;
					case (cls)
						OC_SJUMP: begin
							state_nxt.pc    = bus.sJump;
							state_nxt.fetch = bus.sJump;
						end
						OC_SCALL: begin
							// call range jumps in subroutine pages
							if (bus.inSub) begin
								state_nxt.pc    = bus.sJump;
								state_nxt.fetch = bus.sJump;
							end else begin
								state_nxt.push     = 1'b1;
								state_nxt.pushAddr = bus.pcInc;
								state_nxt.pc       = bus.sCall;
								state_nxt.fetch    = bus.sCall;
							end
						end
						OC_TLATCH, OC_IJUMP: begin
							state_nxt.fetch  = bus.lookAddr;
							state_nxt.jumpHi = bus.lookHi;
							state_nxt.isJump = (cls == OC_IJUMP);
							state_nxt.isMem  = 1'b0;
							state_nxt.st     = ST_LOOK;
						end
						OC_TMEM: begin
							state_nxt.isMem  = 1'b1;
							state_nxt.isJump = 1'b0;
							state_nxt.nop    = 1'b0;
							state_nxt.st     = ST_SECOND;
						end
						OC_LJUMP, OC_LCALL: begin
							state_nxt.farHi  = romData[FARW-1:0];
							state_nxt.isCall = (cls == OC_LCALL);
							state_nxt.isMem  = 1'b0;
							state_nxt.nop    = 1'b0;
							state_nxt.st     = ST_SECOND;
						end
						OC_ASC, OC_COMPLEMENT_ADD_CARRY_SKIP: begin
							state_nxt.accData  = bus.aluSum;
							state_nxt.accWrite = 1'b1;
							state_nxt.carry    = bus.aluCarry;
							state_nxt.skip     = bus.aluCarry;
						end
						OC_ADD_IMMEDIATE_SKIP: begin
							state_nxt.accData  = bus.aluSum;
							state_nxt.accWrite = 1'b1;
							state_nxt.skip     = bus.aluCarry;
						end
						OC_ADD, OC_ADT: begin
							state_nxt.accData  = bus.aluSum;
							state_nxt.accWrite = 1'b1;
						end
						OC_LBI: begin
							state_nxt.digitData  = {1'b0, romData[2:0]};
							state_nxt.digitWrite = 1'b1;
							state_nxt.skip       = 1'b1;
						end
						OC_XIS: begin
							state_nxt.digitData  = digitIn + 4'h1;
							state_nxt.digitWrite = 1'b1;
							state_nxt.skip       = (digitIn == `PSS_NIB_MAX);
						end
						OC_XDS: begin
							state_nxt.digitData  = digitIn - 4'h1;
							state_nxt.digitWrite = 1'b1;
							state_nxt.skip       = (digitIn == `PSS_NIB_MIN);
						end
						OC_RETURN_AND_SKIP, OC_RET: begin
							state_nxt.pop   = 1'b1;
							state_nxt.pc    = retAddr;
							state_nxt.fetch = retAddr;
							state_nxt.skip  = (cls == OC_RETURN_AND_SKIP);
						end
						OC_SKC: state_nxt.skip = state_r.carry;
						OC_SKT: state_nxt.skip = testIn;
						OC_SC:  state_nxt.carry = 1'b1;
						OC_RC:  state_nxt.carry = 1'b0;
						default: state_nxt.skip = 1'b0;
					endcase
				end
			end
			ST_SECOND: begin
				// second byte sits at pc, already past the first
				state_nxt.pc      = bus.pcInc;
				state_nxt.fetch   = bus.pcInc;
				state_nxt.st      = ST_EXEC;
				state_nxt.nop     = 1'b0;
				state_nxt.nopSlot = state_r.nop;
				if (!state_r.nop) begin
					if (state_r.isMem) begin
						// address from pc past both bytes
						state_nxt.fetch = bus.lookAddr;
						state_nxt.st    = ST_LOOK;
					end else begin
						state_nxt.pc = {bus.pcInc[PCW-1:`PSS_CHAP_LSB], state_r.farHi, romData};
						state_nxt.fetch = state_nxt.pc;
						if (state_r.isCall) begin
							state_nxt.push     = 1'b1;
							state_nxt.pushAddr = bus.pcInc;
						end
					end
				end
			end
			ST_LOOK: begin
				// look-up cycle returns fetch to the saved pc, except for the indirect jump
				state_nxt.st    = ST_EXEC;
				state_nxt.fetch = state_r.pc;
				if (state_r.isJump) begin
					// block of the stepped table word
					state_nxt.pc    = {state_r.jumpHi, romData};
					state_nxt.fetch = {state_r.jumpHi, romData};
				end else if (state_r.isMem) begin
					state_nxt.memData  = romData;
					state_nxt.memWrite = 1'b1;
				end else begin
					state_nxt.latchData = romData;
					state_nxt.latchLoad = 1'b1;
				end
			end
			default: state_nxt = REG_RST;
		endcase
	end

	// ------------------------------------------------------------
	// register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= REG_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	// outputs straight from the state record
	assign romAddr    = state_r.fetch;
	assign pcOut      = state_r.pc;
	assign nopSlot    = state_r.nopSlot;
	assign latchLoad  = state_r.latchLoad;
	assign latchData  = state_r.latchData;
	assign memWrite   = state_r.memWrite;
	assign memData    = state_r.memData;
	assign accWrite   = state_r.accWrite;
	assign accData    = state_r.accData;
	assign digitWrite = state_r.digitWrite;
	assign digitData  = state_r.digitData;
	assign stackPush  = state_r.push;
	assign stackAddr  = state_r.pushAddr;
	assign stackPop   = state_r.pop;
	assign carryFlag  = state_r.carry;
	assign skipFlag   = state_r.skip;
	assign seqState   = state_r.st;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_call_page2: assert property (@(posedge clk) disable iff (!arst_n)
		go && cls == OC_SCALL && !bus.inSub |=> stackPush &&
		pcOut == {{(PCW-`PSS_BLK_LSB){1'b0}}, `PSS_TOP_CALL, $past(romData[`PSS_PAGE_LSB-1:0])})
		else $error("page-2 call target wrong");
	a_bf_latch: assert property (@(posedge clk) disable iff (!arst_n)
		go && romData == `PSS_OP_TLATCH |=> !stackPush ##1 latchLoad)
		else $error("BF not a latch look-up");
	a_sub_nocall: assert property (@(posedge clk) disable iff (!arst_n)
		go && cls == OC_SCALL && bus.inSub |=> !stackPush)
		else $error("call in subroutine pages pushed");
	a_short_page: assert property (@(posedge clk) disable iff (!arst_n)
		go && cls == OC_SJUMP && !bus.inSub |=>
		pcOut == {$past(bus.pcInc[PCW-1:6]), $past(romData[5:0])})
		else $error("short jump left its page");
	a_short_sub: assert property (@(posedge clk) disable iff (!arst_n)
		go && cls == OC_SJUMP && bus.inSub |=> pcOut[6:0] == $past(romData[6:0]))
		else $error("short jump range in pages 2-3");
	a_look_addr: assert property (@(posedge clk) disable iff (!arst_n)
		go && cls == OC_TLATCH |=> romAddr == {$past(bus.pcInc[PCW-1:8]),
		$past(accIn), $past(ramIn)})
		else $error("look-up address wrong");
	a_ind_cycles: assert property (@(posedge clk) disable iff (!arst_n)
		go && cls == OC_IJUMP |=> seqState == ST_LOOK ##1 seqState == ST_EXEC)
		else $error("indirect jump cycle count");
	a_skip_nop: assert property (@(posedge clk) disable iff (!arst_n)
		state_r.st == ST_EXEC && state_r.skip |=> nopSlot && !accWrite && !stackPush)
		else $error("skipped slot had effects");
	a_carry_kept: assert property (@(posedge clk) disable iff (!arst_n)
		go && (cls == OC_ADD || cls == OC_ADT || cls == OC_ADD_IMMEDIATE_SKIP) |=> $stable(carryFlag))
		else $error("add changed carry flag");
	a_skc_flag: assert property (@(posedge clk) disable iff (!arst_n)
		go && cls == OC_SKC |=> skipFlag == $past(carryFlag))
		else $error("carry test used wrong source");
	a_asc_carry: assert property (@(posedge clk) disable iff (!arst_n)
		go && cls == OC_ASC |=> carryFlag == $past(bus.aluCarry) &&
		skipFlag == $past(bus.aluCarry))
		else $error("carry add skip or flag wrong");
	a_return_and_skip_skip: assert property (@(posedge clk) disable iff (!arst_n)
		go && cls == OC_RETURN_AND_SKIP |=> skipFlag && stackPop && pcOut == $past(retAddr))
		else $error("return-and-skip wrong");
endmodule // pss_top
`default_nettype wire
